// *** dual_timer_pkg.sv ***
// Constants and types for the dual period timer pair
package dual_timer_pkg;
    // ==========================================================
    // Register indices, banks, byte address = bank*256 + index*4
    localparam logic [7:0] IDX_FIRST_COUNT = 8'h10;
    localparam logic [7:0] IDX_SECOND_COUNT = 8'h11;
    localparam logic [7:0] IDX_FIRST_PERIOD = 8'h14;
    localparam logic [7:0] IDX_SECOND_PERIOD = 8'h15;
    localparam logic [7:0] IDX_FLAGS = 8'h16;
    localparam logic [7:0] IDX_ENABLES = 8'h17;
    localparam logic [7:0] IDX_CONFIG = 8'h16;
    localparam logic [7:0] IDX_CONTROL = 8'h17;
    localparam logic [1:0] BANK_EVENTS = 2'h1;
    localparam logic [1:0] BANK_TIMER = 2'h2;
    localparam logic [1:0] BANK_SETUP = 2'h3;
    localparam int ADDR_W = 12;
    // ==========================================================
    // Field positions and masks
    localparam int CASCADE_BIT = 3;
    localparam int SEL2_BIT = 1;
    localparam int SEL1_BIT = 0;
    localparam int RUN2_BIT = 1;
    localparam int RUN1_BIT = 0;
    localparam int WRAP2_BIT = 5;
    localparam int WRAP1_BIT = 4;
    localparam logic [7:0] FLAG_MASK = 8'h30;
    localparam logic [7:0] CONFIG_MASK = 8'h0B;
    localparam logic [7:0] CONTROL_MASK = 8'h03;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    // ==========================================================
    // Timing: one instruction cycle is four oscillator periods
    localparam int CLK_PERIOD_NS = 50;
    localparam int INSTR_NS = 200;
    localparam int INSTR_CYCLES = INSTR_NS / CLK_PERIOD_NS;
    localparam logic [1:0] DIV_LAST = 2'(INSTR_CYCLES - 1);
    // ==========================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_CNT1, SEL_CNT2, SEL_PER1, SEL_PER2,
        SEL_FLAGS, SEL_EN, SEL_CONFIG, SEL_CTRL
    } reg_sel_t;

    typedef struct packed {
        logic [1:0] extSync;
        logic extPrev;
        logic [1:0] div;
        logic intTick;
        logic [7:0] cnt1;
        logic [7:0] cnt2;
        logic [7:0] per1;
        logic [7:0] per2;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] setup;
        logic [7:0] control;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [7:0] wData;
        logic wLane;
        logic awRdy;
        logic wRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic irq;
    } state_t;
endpackage : dual_timer_pkg

// *** dual_period_timer_pair.sv ***
// Dual 8-bit period timer pair with cascade mode and AXI4-Lite registers
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - First counter wraps at period, sets flag one
// - Second counter wraps at period, sets flag two
// - Shared external pin may clock either timer
// - Flags interrupt only when enabled
// - Cascade joins counters, first is low byte
// - Cascade count wraps at joined period, flag one
// - Cascade uses first clock select only
// - Select clear: instruction clock; set: falling pin
// - External pin synchronised before counting
// - Cascade needs both run bits; first alone: low
// - Config: cascade bit3, selects bits1,0; reset zero
// - Control: run bits 1,0; reset zero
// - Flags bits 5,4; enables same positions
module dual_period_timer_pair (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sharedExtClockPin,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    // ==========================================================
    // Address decode
    function automatic dual_timer_pkg::reg_sel_t decode(input logic [11:0] a);
        logic [1:0] bank;
        logic [7:0] idx;
        dual_timer_pkg::reg_sel_t sel;
        bank = a[9:8];
        idx = {2'h0, a[7:2]};
        sel = dual_timer_pkg::SEL_NONE;
        if (a[11:10] == 2'h0 && a[1:0] == 2'h0) begin
            if (bank == dual_timer_pkg::BANK_TIMER) begin
                if (idx == dual_timer_pkg::IDX_FIRST_COUNT) sel = dual_timer_pkg::SEL_CNT1;
                if (idx == dual_timer_pkg::IDX_SECOND_COUNT) sel = dual_timer_pkg::SEL_CNT2;
                if (idx == dual_timer_pkg::IDX_FIRST_PERIOD) sel = dual_timer_pkg::SEL_PER1;
                if (idx == dual_timer_pkg::IDX_SECOND_PERIOD) sel = dual_timer_pkg::SEL_PER2;
            end
            if (bank == dual_timer_pkg::BANK_EVENTS) begin
                if (idx == dual_timer_pkg::IDX_FLAGS) sel = dual_timer_pkg::SEL_FLAGS;
                if (idx == dual_timer_pkg::IDX_ENABLES) sel = dual_timer_pkg::SEL_EN;
            end
            if (bank == dual_timer_pkg::BANK_SETUP) begin
                if (idx == dual_timer_pkg::IDX_CONFIG) sel = dual_timer_pkg::SEL_CONFIG;
                if (idx == dual_timer_pkg::IDX_CONTROL) sel = dual_timer_pkg::SEL_CTRL;
            end
        end
        return sel;
    endfunction : decode

    // ==========================================================
    // State
    dual_timer_pkg::state_t st_r;
    dual_timer_pkg::state_t st_nxt;
    logic extFall;
    logic tick1;
    logic tick2;
    logic cascade;
    logic run1;
    logic run2;
    logic doWrite;
    logic [7:0] wrapSet;
    dual_timer_pkg::reg_sel_t wrSel;
    dual_timer_pkg::reg_sel_t rdSel;

    always_comb begin
        st_nxt = st_r;
        // First sync stage feeds only the second
        st_nxt.extSync = {st_r.extSync[0], sharedExtClockPin};
        st_nxt.extPrev = st_r.extSync[1];
        extFall = st_r.extPrev & ~st_r.extSync[1];
        st_nxt.div = st_r.div + 2'h1;
        st_nxt.intTick = (st_r.div == dual_timer_pkg::DIV_LAST);
        cascade = st_r.setup[dual_timer_pkg::CASCADE_BIT];
        run1 = st_r.control[dual_timer_pkg::RUN1_BIT];
        run2 = st_r.control[dual_timer_pkg::RUN2_BIT];
        tick1 = st_r.setup[dual_timer_pkg::SEL1_BIT] ? extFall : st_r.intTick;
        if (cascade) begin
            tick2 = tick1;
        end else begin
            tick2 = st_r.setup[dual_timer_pkg::SEL2_BIT] ? extFall : st_r.intTick;
        end
        wrapSet = 8'h00;

        // ======================================================
        // Counting
        if (cascade) begin
            if (run1 && tick1) begin
                if (run2) begin
                    if ({st_r.cnt2, st_r.cnt1} == {st_r.per2, st_r.per1}) begin
                        st_nxt.cnt1 = 8'h00;
                        st_nxt.cnt2 = 8'h00;
                        wrapSet[dual_timer_pkg::WRAP1_BIT] = 1'b1;
                    end else begin
                        {st_nxt.cnt2, st_nxt.cnt1} = {st_r.cnt2, st_r.cnt1} + 16'h0001;
                    end
                end else if (st_r.cnt1 == st_r.per1) begin
                    st_nxt.cnt1 = 8'h00;
                    wrapSet[dual_timer_pkg::WRAP1_BIT] = 1'b1;
                end else begin
                    st_nxt.cnt1 = st_r.cnt1 + 8'h01;
                end
            end
        end else begin
            if (run1 && tick1) begin
                if (st_r.cnt1 == st_r.per1) begin
                    st_nxt.cnt1 = 8'h00;
                    wrapSet[dual_timer_pkg::WRAP1_BIT] = 1'b1;
                end else begin
                    st_nxt.cnt1 = st_r.cnt1 + 8'h01;
                end
            end
            if (run2 && tick2) begin
                if (st_r.cnt2 == st_r.per2) begin
                    st_nxt.cnt2 = 8'h00;
                    wrapSet[dual_timer_pkg::WRAP2_BIT] = 1'b1;
                end else begin
                    st_nxt.cnt2 = st_r.cnt2 + 8'h01;
                end
            end
        end

        // ======================================================
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && st_r.awRdy) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wRdy) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata[7:0];
            st_nxt.wLane = s_axi_wstrb[0];
        end
        doWrite = st_r.awHeld & st_r.wHeld;
        wrSel = decode(st_r.awAddr);
        if (doWrite) begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp = (wrSel == dual_timer_pkg::SEL_NONE) ?
                dual_timer_pkg::RESP_SLVERR : dual_timer_pkg::RESP_OKAY;
        end else if (st_r.bValid && s_axi_bready) begin
            st_nxt.bValid = 1'b0;
        end
        // Software write to a count beats the increment
        if (doWrite && st_r.wLane) begin
            unique case (wrSel)
                dual_timer_pkg::SEL_CNT1: st_nxt.cnt1 = st_r.wData;
                dual_timer_pkg::SEL_CNT2: st_nxt.cnt2 = st_r.wData;
                dual_timer_pkg::SEL_PER1: st_nxt.per1 = st_r.wData;
                dual_timer_pkg::SEL_PER2: st_nxt.per2 = st_r.wData;
                dual_timer_pkg::SEL_FLAGS: begin
                    st_nxt.flags = st_r.flags & ~(st_r.wData & dual_timer_pkg::FLAG_MASK);
                end
                dual_timer_pkg::SEL_EN: begin
                    st_nxt.enables = st_r.wData & dual_timer_pkg::FLAG_MASK;
                end
                dual_timer_pkg::SEL_CONFIG: begin
                    st_nxt.setup = st_r.wData & dual_timer_pkg::CONFIG_MASK;
                end
                dual_timer_pkg::SEL_CTRL: begin
                    st_nxt.control = st_r.wData & dual_timer_pkg::CONTROL_MASK;
                end
                default: begin
                end
            endcase
        end
        // Set wins over a same-cycle clear
        st_nxt.flags = st_nxt.flags | wrapSet;
        st_nxt.awRdy = ~st_nxt.awHeld & ~st_nxt.bValid;
        st_nxt.wRdy = ~st_nxt.wHeld & ~st_nxt.bValid;

        // ======================================================
        // Read channel
        rdSel = decode(s_axi_araddr);
        if (s_axi_arvalid && st_r.arRdy) begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp = dual_timer_pkg::RESP_OKAY;
            unique case (rdSel)
                dual_timer_pkg::SEL_CNT1: st_nxt.rData = {24'h000000, st_r.cnt1};
                dual_timer_pkg::SEL_CNT2: st_nxt.rData = {24'h000000, st_r.cnt2};
                dual_timer_pkg::SEL_PER1: st_nxt.rData = {24'h000000, st_r.per1};
                dual_timer_pkg::SEL_PER2: st_nxt.rData = {24'h000000, st_r.per2};
                dual_timer_pkg::SEL_FLAGS: st_nxt.rData = {24'h000000, st_r.flags};
                dual_timer_pkg::SEL_EN: st_nxt.rData = {24'h000000, st_r.enables};
                dual_timer_pkg::SEL_CONFIG: st_nxt.rData = {24'h000000, st_r.setup};
                dual_timer_pkg::SEL_CTRL: st_nxt.rData = {24'h000000, st_r.control};
                default: begin
                    st_nxt.rData = 32'h00000000;
                    st_nxt.rResp = dual_timer_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_r.rValid && s_axi_rready) begin
            st_nxt.rValid = 1'b0;
        end
        st_nxt.arRdy = ~st_nxt.rValid;
        st_nxt.irq = |(st_nxt.flags & st_nxt.enables & dual_timer_pkg::FLAG_MASK);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awRdy;
    assign s_axi_wready = st_r.wRdy;
    assign s_axi_bvalid = st_r.bValid;
    assign s_axi_bresp = st_r.bResp;
    assign s_axi_arready = st_r.arRdy;
    assign s_axi_rvalid = st_r.rValid;
    assign s_axi_rdata = st_r.rData;
    assign s_axi_rresp = st_r.rResp;
    assign irq = st_r.irq;

    // ==========================================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_irq_gating: assert property (
        irq == |(st_r.flags & st_r.enables & dual_timer_pkg::FLAG_MASK))
        else $error("irq does not follow enabled flags");
    a_first_wrap: assert property (
        !cascade && run1 && tick1 && st_r.cnt1 == st_r.per1 && !doWrite
        |=> st_r.cnt1 == 8'h00 && st_r.flags[dual_timer_pkg::WRAP1_BIT])
        else $error("first counter wrap wrong");
    a_second_wrap: assert property (
        !cascade && run2 && tick2 && st_r.cnt2 == st_r.per2 && !doWrite
        |=> st_r.cnt2 == 8'h00 && st_r.flags[dual_timer_pkg::WRAP2_BIT])
        else $error("second counter wrap wrong");
    a_cascade_wrap: assert property (
        cascade && run1 && run2 && tick1 && !doWrite
        && {st_r.cnt2, st_r.cnt1} == {st_r.per2, st_r.per1}
        |=> {st_r.cnt2, st_r.cnt1} == 16'h0000 && st_r.flags[dual_timer_pkg::WRAP1_BIT])
        else $error("cascade wrap wrong");
    a_cascade_low_only: assert property (
        cascade && run1 && !run2 && !doWrite |=> $stable(st_r.cnt2))
        else $error("high byte moved with second run clear");
    a_cascade_stopped: assert property (
        cascade && !run1 && !doWrite |=> $stable(st_r.cnt1) && $stable(st_r.cnt2))
        else $error("cascade ran with first run clear");
    a_instr_period: assert property (
        st_r.intTick |=> !st_r.intTick [*3] ##1 st_r.intTick)
        else $error("instruction tick period wrong");
    a_ext_sync_edge: assert property (
        extFall |-> $past(st_r.extSync[1]) && !st_r.extSync[1] && $past(sharedExtClockPin, 3))
        else $error("external edge not synchronised");
    a_reset_setup: assert property (
        $past(rst) |-> st_r.setup == dual_timer_pkg::RST_CONFIG
        && st_r.control == dual_timer_pkg::RST_CONTROL)
        else $error("setup registers not cleared by reset");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");

    c_cascade_wrap: cover property (
        cascade && run1 && run2 && tick1 && {st_r.cnt2, st_r.cnt1} == {st_r.per2, st_r.per1});
    c_ext_count: cover property (run1 && st_r.setup[dual_timer_pkg::SEL1_BIT] && extFall);
    c_both_wrap: cover property (wrapSet == dual_timer_pkg::FLAG_MASK);
    c_irq_rise: cover property ($rose(irq));
endmodule : dual_period_timer_pair

// *** ext_clock_source.sv ***
// Model of the external clock source that drives the shared counter pin
`timescale 1ns/1ps
module ext_clock_source (
    output logic pin
);
    // ==========================================
    // Idle level
    // The pin has a pull-up, so between bursts it rests high
    initial begin
        pin = 1'b1;
    end

    // ==========================================
    // Bursts of falling edges
    // The half period is free so that both fast and slow sources can be shown
    task automatic falls(input int n, input int halfNs);
        begin
            for (int i = 0; i < n; i++) begin
                #(halfNs) pin = 1'b0;
                #(halfNs) pin = 1'b1;
            end
        end
    endtask : falls
endmodule : ext_clock_source

// *** test_dual_period_timer_pair.sv ***
// Self-checking bench for the dual period timer pair
`timescale 1ns/1ps
module test_dual_period_timer_pair;
    // ==========================================
    // Signals and instances
    logic ref_clk, rst, extPin, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errCount;
    int checksDone;

    function automatic logic [11:0] ra(input logic [1:0] bank, input logic [7:0] idx);
        return {2'b00, bank, 8'h00} + {2'b00, idx, 2'b00};
    endfunction : ra

    localparam logic [11:0] CNT1 = ra(dual_timer_pkg::BANK_TIMER, dual_timer_pkg::IDX_FIRST_COUNT);
    localparam logic [11:0] CNT2 = ra(dual_timer_pkg::BANK_TIMER, dual_timer_pkg::IDX_SECOND_COUNT);
    localparam logic [11:0] PER1 = ra(dual_timer_pkg::BANK_TIMER, dual_timer_pkg::IDX_FIRST_PERIOD);
    localparam logic [11:0] PER2 = ra(dual_timer_pkg::BANK_TIMER, dual_timer_pkg::IDX_SECOND_PERIOD);
    localparam logic [11:0] FLG = ra(dual_timer_pkg::BANK_EVENTS, dual_timer_pkg::IDX_FLAGS);
    localparam logic [11:0] ENA = ra(dual_timer_pkg::BANK_EVENTS, dual_timer_pkg::IDX_ENABLES);
    localparam logic [11:0] CFG = ra(dual_timer_pkg::BANK_SETUP, dual_timer_pkg::IDX_CONFIG);
    localparam logic [11:0] CTL = ra(dual_timer_pkg::BANK_SETUP, dual_timer_pkg::IDX_CONTROL);

    ext_clock_source ext (.pin(extPin));

    dual_period_timer_pair DUT (.ref_clk, .rst, .sharedExtClockPin(extPin),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ==========================================
    // Reporting
    task automatic endSim();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : endSim

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stall();
        errCount++;
        $display("wrong value bus answer expected within 40 cycles seen none");
        endSim();
    endtask : stall

    // ==========================================
    // Bus master; one extra edge at the end so no strobe is driven twice at once
    task automatic wrx(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                check("write response", 32'(s_axi_bresp), 32'(resp));
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
            if (n > 40) stall();
        end
        @(posedge ref_clk);
    endtask : wrx

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        wrx(a, d, dual_timer_pkg::RESP_OKAY);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [1:0] resp, output logic [31:0] data);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        data = '0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                data = s_axi_rdata;
                check("read response", 32'(s_axi_rresp), 32'(resp));
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
            if (n > 40) stall();
        end
        @(posedge ref_clk);
    endtask : rd

    task automatic rc(input string what, input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] d;
        rd(a, dual_timer_pkg::RESP_OKAY, d);
        check(what, d, {24'h0, exp});
    endtask : rc

    // ==========================================
    // Scenarios
    task automatic test_reset_values();
        logic [31:0] d;
        rc("config after reset", CFG, 8'h00);
        rc("control after reset", CTL, 8'h00);
        rc("flags after reset", FLG, 8'h00);
        rc("enables after reset", ENA, 8'h00);
        wr(CFG, 8'hFF);
        rc("config fields", CFG, 8'h0B);
        wr(CTL, 8'hFC);
        rc("control fields", CTL, 8'h00);
        rd(ra(2'h0, 8'h10), dual_timer_pkg::RESP_SLVERR, d);
        check("unmapped read data", d, 32'h0);
        wrx(ra(2'h0, 8'h10), 8'h55, dual_timer_pkg::RESP_SLVERR);
        wr(CFG, 8'h00);
    endtask : test_reset_values

    task automatic test_first_internal();
        logic [31:0] d;
        wr(PER1, 8'h05);
        wr(CNT1, 8'h00);
        wr(CTL, 8'h01);
        // Six ticks of four cycles reach the wrap, the second wrap needs 48
        repeat (40) @(posedge ref_clk);
        wr(CTL, 8'h00);
        rc("first wrap flag", FLG, 8'h10);
        check("irq while masked", 32'(irq), 32'h0);
        rd(CNT1, dual_timer_pkg::RESP_OKAY, d);
        check("first count within period", 32'(d[7:0] <= 8'h05), 32'h1);
        wr(ENA, 8'h10);
        check("irq when enabled", 32'(irq), 32'h1);
        wr(FLG, 8'h10);
        check("irq after clear", 32'(irq), 32'h0);
        rc("flags after clear", FLG, 8'h00);
    endtask : test_first_internal

    task automatic test_second_external();
        wr(CFG, 8'h02);
        wr(PER2, 8'h02);
        wr(CNT2, 8'h00);
        wr(CTL, 8'h02);
        ext.falls(2, 170);
        repeat (8) @(posedge ref_clk);
        rc("second count on pin", CNT2, 8'h02);
        rc("no wrap yet", FLG, 8'h00);
        ext.falls(1, 470);
        repeat (8) @(posedge ref_clk);
        rc("second count wrapped", CNT2, 8'h00);
        rc("second wrap flag", FLG, 8'h20);
        wr(CTL, 8'h00);
        wr(FLG, 8'h30);
    endtask : test_second_external

    task automatic test_cascade();
        logic [31:0] d;
        // Second select set but must be ignored; no pin edges are given
        wr(CFG, 8'h0B);
        wr(PER1, 8'hFF);
        wr(PER2, 8'h01);
        wr(CNT1, 8'hFE);
        wr(CNT2, 8'h00);
        wr(CTL, 8'h02);
        repeat (20) @(posedge ref_clk);
        rc("cascade off", CNT1, 8'hFE);
        wr(CFG, 8'h0A);
        wr(CTL, 8'h03);
        repeat (40) @(posedge ref_clk);
        wr(CTL, 8'h00);
        rc("carry into high byte", CNT2, 8'h01);
        rc("no wrap below period", FLG, 8'h00);
        wr(CNT1, 8'hFD);
        wr(CNT2, 8'h01);
        wr(CTL, 8'h03);
        repeat (40) @(posedge ref_clk);
        wr(CTL, 8'h00);
        rc("high byte after wrap", CNT2, 8'h00);
        rd(CNT1, dual_timer_pkg::RESP_OKAY, d);
        check("low byte after wrap", 32'(d[7:0] <= 8'h0C), 32'h1);
        rc("cascade wrap flag", FLG, 8'h10);
        check("irq on cascade wrap", 32'(irq), 32'h1);
        wr(CNT1, 8'h00);
        wr(CNT2, 8'h00);
        wr(CTL, 8'h01);
        repeat (20) @(posedge ref_clk);
        wr(CTL, 8'h00);
        rc("high byte with first run only", CNT2, 8'h00);
        rd(CNT1, dual_timer_pkg::RESP_OKAY, d);
        check("low byte runs alone", 32'(d[7:0] != 8'h00), 32'h1);
    endtask : test_cascade

    // ==========================================
    // Main sequence
    initial begin
        errCount = 0;
        checksDone = 0;
        rst = 1'b1;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        test_reset_values();
        test_first_internal();
        test_second_external();
        test_cascade();
        endSim();
    end
endmodule : test_dual_period_timer_pair
